// ---- inc/vds_pkg.sv ----
package vds_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned MS_HZ = 1000;
   localparam int unsigned MS_DIV = CLK_HZ / MS_HZ;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MANUAL_MAX_S = 10;
   localparam int unsigned MANUAL_MAX_MS = MANUAL_MAX_S * MS_PER_S;

   // Widths
   localparam int unsigned DW = 32;
   localparam int unsigned AW = 8;
   localparam int unsigned TW = 16;
   localparam int unsigned BW = 8;
   localparam int unsigned MODE_W = 2;
   localparam int unsigned IRQ_W = 4;

   // Register offsets
   localparam logic [AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [AW-1:0] OFF_OPEN = 8'h04;
   localparam logic [AW-1:0] OFF_PERIOD = 8'h08;
   localparam logic [AW-1:0] OFF_COUNT = 8'h0C;
   localparam logic [AW-1:0] OFF_DONE = 8'h10;
   localparam logic [AW-1:0] OFF_HOLD = 8'h14;
   localparam logic [AW-1:0] OFF_TLIM = 8'h18;
   localparam logic [AW-1:0] OFF_STAT = 8'h1C;
   localparam logic [AW-1:0] OFF_ISTAT = 8'h20;
   localparam logic [AW-1:0] OFF_ICLR = 8'h24;
   localparam logic [AW-1:0] OFF_IEN = 8'h28;

   // Control register fields
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_PWR_BIT = 2;
   localparam int unsigned CTRL_HEAT_LSB = 3;
   localparam int unsigned CTRL_CYCLE_BIT = 8;
   localparam int unsigned CTRL_FRST_BIT = 9;

   // Valve modes
   localparam logic [MODE_W-1:0] MODE_TIMED = 2'h0;
   localparam logic [MODE_W-1:0] MODE_CONT = 2'h1;
   localparam logic [MODE_W-1:0] MODE_EXT = 2'h2;

   // Heater modes
   localparam logic [MODE_W-1:0] HEAT_OFF = 2'h0;
   localparam logic [MODE_W-1:0] HEAT_ON = 2'h1;
   localparam logic [MODE_W-1:0] HEAT_REMOTE = 2'h2;

   // Factory defaults and done length limits
   localparam logic [TW-1:0] DEF_OPEN_MS = 16'h000A;
   localparam logic [TW-1:0] DEF_PERIOD_MS = 16'h0014;
   localparam logic [TW-1:0] DEF_COUNT = 16'h0001;
   localparam logic [TW-1:0] DEF_HOLD_MS = 16'h2710;
   localparam logic [BW-1:0] DEF_DONE_MS = 8'h06;
   localparam logic [BW-1:0] DONE_MIN_MS = 8'h01;
   localparam logic [BW-1:0] DONE_MAX_MS = 8'h64;
   localparam logic [BW-1:0] DEF_TLIM_C = 8'h37;

   // Interrupt status bits
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_OVT = 1;
   localparam int unsigned IRQ_DISP = 2;
   localparam int unsigned IRQ_DROP = 3;

   // Status register bits
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_OVT = 1;
   localparam int unsigned STAT_HEAT = 2;
   localparam int unsigned STAT_DRIVE = 3;
   localparam int unsigned STAT_OPEN = 4;
   localparam int unsigned STAT_DONE = 5;

   typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_GAP, ST_MANUAL} vds_state_t;
endpackage : vds_pkg

// ---- inc/vds_tick_if.sv ----
`timescale 1ns/1ps
interface vds_tick_if;
   logic clr;
   logic tick;
   modport ctl (output clr, input tick);
   modport gen (input clr, output tick);
endinterface : vds_tick_if

// ---- hdl/vds_ms_tick.sv ----
`timescale 1ns/1ps
module vds_ms_tick
   import vds_pkg::*;
#(
   parameter int unsigned DIV = MS_DIV
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Tick link
   vds_tick_if.gen tk
);
   localparam int unsigned CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } vds_tick_st_t;

   vds_tick_st_t s_r;
   vds_tick_st_t s_nxt;

   // Millisecond divider, restartable
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (tk.clr) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt == LAST) begin
         s_nxt.cnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tk.tick = s_r.tick;
endmodule : vds_ms_tick

// ---- hdl/vds_top.sv ----
`timescale 1ns/1ps
module vds_top
   import vds_pkg::*;
#(
   parameter int unsigned MS_DIV_P = MS_DIV,
   parameter logic PWR_DEFAULT = 1'b1
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // Register port
   input wire logic [AW-1:0] I_ADDR,
   input wire logic [DW-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [DW-1:0] O_RDATA,
   // Machine and sensor inputs
   input wire logic I_INIT,
   input wire logic I_HEAT_REMOTE,
   input wire logic [BW-1:0] I_STACK_TEMP,
   // Valve and status outputs
   output logic O_VALVE_DRIVE,
   output logic O_VALVE_OPEN,
   output logic O_DONE,
   output logic O_HEATER_EN,
   output logic O_OVERTEMP,
   output logic O_DISP_RESTART,
   output logic O_IRQ
);
   typedef struct packed {
      logic [2:0] sy_init;
      logic [1:0] sy_heat;
      logic [MODE_W-1:0] mode;
      logic pwr;
      logic [MODE_W-1:0] heat_mode;
      logic [TW-1:0] open_ms;
      logic [TW-1:0] period_ms;
      logic [TW-1:0] count;
      logic [TW-1:0] hold_ms;
      logic [BW-1:0] done_ms;
      logic [BW-1:0] tlim;
      vds_state_t st;
      logic [TW-1:0] ms_cnt;
      logic [TW-1:0] left;
      logic [BW-1:0] done_cnt;
      logic done;
      logic valve_open;
      logic drive;
      logic heat_en;
      logic ovt;
      logic restart;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_en;
      logic [DW-1:0] rdata;
   } vds_st_t;

   localparam vds_st_t ST_RST = '{
      pwr: PWR_DEFAULT,
      mode: MODE_TIMED,
      heat_mode: HEAT_OFF,
      open_ms: DEF_OPEN_MS,
      period_ms: DEF_PERIOD_MS,
      count: DEF_COUNT,
      hold_ms: DEF_HOLD_MS,
      done_ms: DEF_DONE_MS,
      tlim: DEF_TLIM_C,
      st: ST_IDLE,
      drive: PWR_DEFAULT,
      default: '0
   };
   localparam logic [TW-1:0] MAN_MAX = TW'(MANUAL_MAX_MS);
   localparam logic [TW-1:0] ONE = 16'h0001;

   vds_st_t s_r;
   vds_st_t s_nxt;
   vds_tick_if tk ();

   vds_ms_tick #(
      .DIV(MS_DIV_P)
   ) u_tick (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .tk(tk.gen)
   );

   logic init_lvl;
   logic init_rise;
   logic wr_ctrl;
   logic manual;
   logic frst;
   logic finish;
   logic tick_clr;
   logic mode_chg;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [TW-1:0] ms_next;
   logic [TW-1:0] man_lim;
   logic [BW-1:0] done_w;
   logic [MODE_W-1:0] new_mode;

   always_comb begin
      s_nxt = s_r;
      s_nxt.restart = 1'b0;
      s_nxt.rdata = '0;
      irq_set = '0;
      irq_clr = '0;
      finish = 1'b0;
      tick_clr = 1'b0;
      // Input synchronisers, stage 0 feeds stage 1 only
      s_nxt.sy_init = {s_r.sy_init[1:0], I_INIT};
      s_nxt.sy_heat = {s_r.sy_heat[0], I_HEAT_REMOTE};
      // in timed mode only a synchronised rising edge is a trigger, continuous mode uses the level
      init_lvl = s_r.sy_init[1];
      init_rise = s_r.sy_init[1] & ~s_r.sy_init[2];
      wr_ctrl = I_WR && (I_ADDR == OFF_CTRL);
      manual = wr_ctrl && I_WDATA[CTRL_CYCLE_BIT];
      frst = wr_ctrl && I_WDATA[CTRL_FRST_BIT];
      new_mode = I_WDATA[CTRL_MODE_LSB +: MODE_W];
      mode_chg = wr_ctrl && (new_mode != s_r.mode);
      ms_next = s_r.ms_cnt + ONE;
      man_lim = (s_r.hold_ms < MAN_MAX) ? s_r.hold_ms : MAN_MAX;
      done_w = I_WDATA[BW-1:0];
      if (tk.tick) begin
         s_nxt.ms_cnt = ms_next;
      end

      // Register writes
      if (I_WR) begin
         case (I_ADDR)
            OFF_CTRL: begin
               s_nxt.mode = new_mode;
               s_nxt.pwr = I_WDATA[CTRL_PWR_BIT];
               s_nxt.heat_mode = I_WDATA[CTRL_HEAT_LSB +: MODE_W];
            end
            OFF_OPEN: s_nxt.open_ms = I_WDATA[TW-1:0];
            OFF_PERIOD: s_nxt.period_ms = I_WDATA[TW-1:0];
            OFF_COUNT: s_nxt.count = I_WDATA[TW-1:0];
            OFF_HOLD: s_nxt.hold_ms = I_WDATA[TW-1:0];
            OFF_DONE: begin
               if (done_w < DONE_MIN_MS) begin
                  s_nxt.done_ms = DONE_MIN_MS;
               end else if (done_w > DONE_MAX_MS) begin
                  s_nxt.done_ms = DONE_MAX_MS;
               end else begin
                  s_nxt.done_ms = done_w;
               end
            end
            OFF_TLIM: s_nxt.tlim = I_WDATA[BW-1:0];
            OFF_ICLR: irq_clr = I_WDATA[IRQ_W-1:0];
            OFF_IEN: s_nxt.irq_en = I_WDATA[IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      // Register reads
      if (I_RD) begin
         case (I_ADDR)
            OFF_CTRL: begin
               s_nxt.rdata[CTRL_MODE_LSB +: MODE_W] = s_r.mode;
               s_nxt.rdata[CTRL_PWR_BIT] = s_r.pwr;
               s_nxt.rdata[CTRL_HEAT_LSB +: MODE_W] = s_r.heat_mode;
            end
            OFF_OPEN: s_nxt.rdata[TW-1:0] = s_r.open_ms;
            OFF_PERIOD: s_nxt.rdata[TW-1:0] = s_r.period_ms;
            OFF_COUNT: s_nxt.rdata[TW-1:0] = s_r.count;
            OFF_HOLD: s_nxt.rdata[TW-1:0] = s_r.hold_ms;
            OFF_DONE: s_nxt.rdata[BW-1:0] = s_r.done_ms;
            OFF_TLIM: s_nxt.rdata[BW-1:0] = s_r.tlim;
            OFF_STAT: begin
               s_nxt.rdata[STAT_BUSY] = (s_r.st != ST_IDLE);
               s_nxt.rdata[STAT_OVT] = s_r.ovt;
               s_nxt.rdata[STAT_HEAT] = s_r.heat_en;
               s_nxt.rdata[STAT_DRIVE] = s_r.drive;
               s_nxt.rdata[STAT_OPEN] = s_r.valve_open;
               s_nxt.rdata[STAT_DONE] = s_r.done;
            end
            OFF_ISTAT: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_st;
            OFF_IEN: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_en;
            default: begin
            end
         endcase
      end

      // Dispense sequencer
      if (!s_r.pwr) begin
         s_nxt.st = ST_IDLE;
         if (init_rise || manual) begin
            irq_set[IRQ_DROP] = 1'b1;
         end
      end else begin
         unique case (s_r.st)
            ST_IDLE: begin
               if (s_r.mode == MODE_TIMED) begin
                  if (manual) begin
                     s_nxt.left = ONE;
                     s_nxt.st = ST_OPEN;
                     tick_clr = 1'b1;
                  end else if (init_rise) begin
                     s_nxt.left = (s_r.count == '0) ? ONE : s_r.count;
                     s_nxt.st = ST_OPEN;
                     tick_clr = 1'b1;
                  end
               end else if (s_r.mode == MODE_CONT) begin
                  if (manual) begin
                     s_nxt.st = ST_MANUAL;
                     tick_clr = 1'b1;
                  end else if (init_lvl) begin
                     s_nxt.st = ST_OPEN;
                     tick_clr = 1'b1;
                  end
               end
            end
            ST_OPEN: begin
               if (tk.tick && (ms_next >= s_r.open_ms)) begin
                  tick_clr = 1'b1;
                  if ((s_r.mode == MODE_TIMED) && (s_r.left <= ONE)) begin
                     s_nxt.st = ST_IDLE;
                     finish = 1'b1;
                  end else begin
                     s_nxt.st = ST_GAP;
                     s_nxt.left = s_r.left - ONE;
                  end
               end
            end
            ST_GAP: begin
               if (tk.tick && (ms_next >= s_r.period_ms)) begin
                  tick_clr = 1'b1;
                  if ((s_r.mode == MODE_TIMED) || init_lvl) begin
                     s_nxt.st = ST_OPEN;
                  end else begin
                     s_nxt.st = ST_IDLE;
                     finish = 1'b1;
                  end
               end
            end
            ST_MANUAL: begin
               if (manual || (tk.tick && (ms_next >= man_lim))) begin
                  s_nxt.st = ST_IDLE;
                  tick_clr = 1'b1;
                  finish = 1'b1;
               end
            end
         endcase
      end
      if (mode_chg) begin
         s_nxt.st = ST_IDLE;
      end
      if (tick_clr) begin
         s_nxt.ms_cnt = '0;
      end

      if (finish) begin
         s_nxt.done = 1'b1;
         s_nxt.done_cnt = s_r.done_ms;
         irq_set[IRQ_DONE] = 1'b1;
      end else if (s_r.done && tk.tick) begin
         if (s_r.done_cnt <= DONE_MIN_MS) begin
            s_nxt.done = 1'b0;
         end else begin
            s_nxt.done_cnt = s_r.done_cnt - DONE_MIN_MS;
         end
      end

      if (frst) begin
         s_nxt.mode = ST_RST.mode;
         s_nxt.pwr = ST_RST.pwr;
         s_nxt.heat_mode = ST_RST.heat_mode;
         s_nxt.open_ms = ST_RST.open_ms;
         s_nxt.period_ms = ST_RST.period_ms;
         s_nxt.count = ST_RST.count;
         s_nxt.hold_ms = ST_RST.hold_ms;
         s_nxt.done_ms = ST_RST.done_ms;
         s_nxt.tlim = ST_RST.tlim;
         s_nxt.irq_en = ST_RST.irq_en;
         s_nxt.st = ST_IDLE;
         s_nxt.restart = 1'b1;
         irq_set[IRQ_DISP] = 1'b1;
      end

      s_nxt.drive = s_nxt.pwr;
      if (!s_nxt.pwr) begin
         s_nxt.valve_open = 1'b1;
      end else if (s_r.mode == MODE_EXT) begin
         s_nxt.valve_open = init_lvl;
      end else begin
         s_nxt.valve_open = (s_nxt.st == ST_OPEN) || (s_nxt.st == ST_MANUAL);
      end

      s_nxt.ovt = (I_STACK_TEMP >= s_r.tlim);
      if (s_nxt.ovt && !s_r.ovt) begin
         irq_set[IRQ_OVT] = 1'b1;
      end

      case (s_r.heat_mode)
         HEAT_ON: s_nxt.heat_en = 1'b1;
         HEAT_REMOTE: s_nxt.heat_en = s_r.sy_heat[1];
         default: s_nxt.heat_en = 1'b0;
      endcase

      // Sticky status, set wins over clear
      s_nxt.irq_st = (s_r.irq_st & ~irq_clr) | irq_set;
   end

   assign tk.clr = tick_clr;

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign O_RDATA = s_r.rdata;
   assign O_VALVE_DRIVE = s_r.drive;
   assign O_VALVE_OPEN = s_r.valve_open;
   assign O_DONE = s_r.done;
   assign O_HEATER_EN = s_r.heat_en;
   assign O_OVERTEMP = s_r.ovt;
   assign O_DISP_RESTART = s_r.restart;
   assign O_IRQ = |(s_r.irq_st & s_r.irq_en);
endmodule : vds_top

// ---- testbench/vds_monitor.sv ----
`timescale 1ns/1ps
module vds_monitor
   import vds_pkg::*;
#(
   parameter int unsigned MS_DIV_P = MS_DIV
) (
   // Clock, reset and register port
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic [AW-1:0] I_ADDR,
   input wire logic [DW-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [DW-1:0] O_RDATA,
   // Pins
   input wire logic I_INIT,
   input wire logic I_HEAT_REMOTE,
   input wire logic [BW-1:0] I_STACK_TEMP,
   input wire logic O_VALVE_DRIVE,
   input wire logic O_VALVE_OPEN,
   input wire logic O_DONE,
   input wire logic O_HEATER_EN,
   input wire logic O_OVERTEMP,
   input wire logic O_DISP_RESTART
);
   logic ctrl_wr;
   logic pwr_r;
   logic [1:0] mode_r;
   logic [1:0] heat_r;
   logic [15:0] done_cnt_r;
   assign ctrl_wr = I_WR && (I_ADDR == OFF_CTRL);
   // Shadow of control fields, length of the done level
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pwr_r <= 1'b1;
         mode_r <= MODE_TIMED;
         heat_r <= HEAT_OFF;
         done_cnt_r <= '0;
      end else begin
         if (ctrl_wr) begin
            pwr_r <= I_WDATA[CTRL_PWR_BIT];
            mode_r <= I_WDATA[CTRL_MODE_LSB +: MODE_W];
            heat_r <= I_WDATA[CTRL_HEAT_LSB +: MODE_W];
         end
         done_cnt_r <= O_DONE ? done_cnt_r + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RSTN);
   sequence s_frst;
      ctrl_wr && I_WDATA[CTRL_FRST_BIT];
   endsequence
   sequence s_pulse;
      O_DISP_RESTART ##1 !O_DISP_RESTART;
   endsequence
   sequence s_ext_steady;
      (mode_r == MODE_EXT && pwr_r && $stable(I_INIT)) [*5];
   endsequence
   property p_off_open;
      !O_VALVE_DRIVE |-> O_VALVE_OPEN;
   endproperty
   property p_drive;
      $stable(pwr_r) [*3] |-> O_VALVE_DRIVE == pwr_r;
   endproperty
   property p_ext;
      s_ext_steady |-> O_VALVE_OPEN == I_INIT;
   endproperty
   property p_heat;
      ($stable(heat_r) && heat_r != HEAT_REMOTE) [*3] |-> O_HEATER_EN == (heat_r == HEAT_ON);
   endproperty
   property p_heat_rem;
      (heat_r == HEAT_REMOTE && $stable(I_HEAT_REMOTE)) [*5] |-> O_HEATER_EN == I_HEAT_REMOTE;
   endproperty
   property p_ovt;
      1'b1 |=> O_OVERTEMP == ($past(I_STACK_TEMP) >= DEF_TLIM_C);
   endproperty
   property p_rd_idle;
      !I_RD |=> O_RDATA == '0;
   endproperty
   property p_frst;
      s_frst |=> s_pulse;
   endproperty
   property p_done_len;
      $fell(O_DONE) |-> done_cnt_r >= 5 * MS_DIV_P && done_cnt_r <= 7 * MS_DIV_P;
   endproperty
   a_off_open: assert property (p_off_open)
      else $error("valve shut while undriven");
   a_drive: assert property (p_drive)
      else $error("valve drive differs from power setting");
   a_ext: assert property (p_ext)
      else $error("external mode valve not following initiate");
   a_heat: assert property (p_heat)
      else $error("heater level wrong for forced mode");
   a_heat_rem: assert property (p_heat_rem)
      else $error("heater not following remote line");
   a_ovt: assert property (p_ovt)
      else $error("overtemp alarm wrong for stack temperature");
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read answer");
   a_frst: assert property (p_frst)
      else $error("display restart pulse missing after settings reset");
   a_done_len: assert property (p_done_len)
      else $error("done level length wrong");
endmodule : vds_monitor

bind vds_top vds_monitor #(.MS_DIV_P(MS_DIV_P)) u_mon (
   .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
   .I_RD(I_RD), .O_RDATA(O_RDATA), .I_INIT(I_INIT), .I_HEAT_REMOTE(I_HEAT_REMOTE),
   .I_STACK_TEMP(I_STACK_TEMP), .O_VALVE_DRIVE(O_VALVE_DRIVE),
   .O_VALVE_OPEN(O_VALVE_OPEN), .O_DONE(O_DONE), .O_HEATER_EN(O_HEATER_EN),
   .O_OVERTEMP(O_OVERTEMP), .O_DISP_RESTART(O_DISP_RESTART));

// ---- testbench/vds_init_drv.sv ----
`timescale 1ns/1ps
module vds_init_drv (
   // Clock
   input wire logic i_clk,
   // Initiate line
   output logic o_init
);
   initial o_init = 1'b0;
   task automatic level(input logic v);
      @(posedge i_clk);
      o_init <= v;
   endtask : level
   // one clean pulse, n cycles high
   task automatic pulse(input int n);
      level(1'b1);
      repeat (n) @(posedge i_clk);
      o_init <= 1'b0;
   endtask : pulse
endmodule : vds_init_drv

// ---- testbench/vds_tb_top.sv ----
`timescale 1ns/1ps
module vds_tb_top
   import vds_pkg::*;
;
   localparam int unsigned DIV = 4;
   logic clk = 1'b0;
   logic rstn;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic wr_s;
   logic rd_s;
   logic heat_in;
   logic [BW-1:0] temp;
   logic [DW-1:0] rdata, v;
   logic init, o_drive, o_open, o_done, o_heat, o_ovt, o_disp, o_irq;
   logic was_open = 1'b0;
   logic saw_disp = 1'b0;
   int errors = 0;
   int total_checks = 0;
   int opens = 0;
   int wid = 0;
   int w = 0;
   int span = 0;
   int cnt, op, per;
   logic [AW-1:0] ra[9] = '{OFF_CTRL, OFF_OPEN, OFF_PERIOD, OFF_COUNT, OFF_DONE, OFF_HOLD,
      OFF_TLIM, OFF_IEN, 8'h30};
   logic [DW-1:0] rv[9] = '{32'h4, 32'hA, 32'h14, 32'h1, 32'h6, 32'h2710, 32'h37, 32'h0, 32'h0};

   always #25 clk = ~clk;

   vds_init_drv u_drv (.i_clk(clk), .o_init(init));
   vds_top #(.MS_DIV_P(DIV)) u_dut (
      .I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
      .I_RD(rd_s), .O_RDATA(rdata), .I_INIT(init), .I_HEAT_REMOTE(heat_in),
      .I_STACK_TEMP(temp), .O_VALVE_DRIVE(o_drive), .O_VALVE_OPEN(o_open),
      .O_DONE(o_done), .O_HEATER_EN(o_heat), .O_OVERTEMP(o_ovt),
      .O_DISP_RESTART(o_disp), .O_IRQ(o_irq));

   // Open pulse count, last width, span from first open
   always @(negedge clk) begin
      if (o_open && !was_open) opens++;
      w = o_open ? w + 1 : 0;
      if (o_open) wid = w;
      if (opens == 0) span = 0;
      else if (!o_done) span++;
      if (o_disp) saw_disp = 1'b1;
      was_open = o_open;
   end

   function automatic logic [DW-1:0] ctl(input logic [1:0] m, input logic p,
      input logic [1:0] h, input logic c, input logic f);
      return DW'({f, c, 3'h0, h, p, m});
   endfunction : ctl

   function automatic int seq_c(input int c, input int o, input int p);
      return (c * o + (c - 1) * p) * DIV;
   endfunction : seq_c

   task automatic chk(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk

   task automatic st(input int n);
      repeat (n) @(negedge clk);
   endtask : st

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), rdata, e);
   endtask : rc

   task automatic wait_done();
      int i;
      i = 0;
      while (o_done !== 1'b1 && i < 2000) begin
         st(1);
         i++;
      end
      chk("done", o_done, 1'b1);
   endtask : wait_done

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   initial begin
      #(50 * 60000);
      errors++;
      summarize();
   end

   initial begin
      rstn <= 1'b0;
      addr <= '0;
      wdata <= '0;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      void'($urandom(32'h1f37));
      heat_in <= 1'($urandom % 2);
      temp <= 8'($urandom % 8'h37);
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      st(1);
      chk("drive", o_drive, 1'b1);
      foreach (ra[i]) rc(ra[i], rv[i]);
      wr(OFF_DONE, 32'h0);
      rc(OFF_DONE, 32'h1);
      wr(OFF_DONE, 32'hC8);
      rc(OFF_DONE, 32'h64);
      wr(OFF_DONE, 32'h6);
      wr(OFF_IEN, 32'h1);
      repeat (3) begin
         cnt = 2 + $urandom % 3;
         op = 2 + $urandom % 2;
         per = 1 + $urandom % 3;
         wr(OFF_OPEN, op);
         wr(OFF_PERIOD, per);
         wr(OFF_COUNT, cnt);
         wr(OFF_ICLR, 32'hF);
         opens = 0;
         u_drv.pulse(2);
         st(4);
         u_drv.pulse(2);
         wait_done();
         chk("opens", opens, cnt);
         chk("width", wid >= op * DIV && wid <= op * DIV + 2, 1'b1);
         chk("span", span >= seq_c(cnt, op, per) && span <= seq_c(cnt, op, per) + 4 * cnt,
            1'b1);
         st(3);
         chk("irq", o_irq, 1'b1);
         st(8 * DIV);
      end
      wr(OFF_IEN, 32'h0);
      st(3);
      chk("irq", o_irq, 1'b0);
      wr(OFF_IEN, 32'h1);
      wr(OFF_ICLR, 32'hF);
      rc(OFF_ISTAT, 32'h0);
      chk("irq", o_irq, 1'b0);
      opens = 0;
      wr(OFF_CTRL, ctl(MODE_TIMED, 1'b1, HEAT_OFF, 1'b1, 1'b0));
      wait_done();
      chk("manual", opens, 1);
      st(8 * DIV);
      wr(OFF_COUNT, 32'h1);
      wr(OFF_CTRL, ctl(MODE_CONT, 1'b1, HEAT_OFF, 1'b0, 1'b0));
      opens = 0;
      u_drv.level(1'b1);
      st(60);
      u_drv.level(1'b0);
      wait_done();
      chk("cont", opens >= 3, 1'b1);
      st(8 * DIV);
      wr(OFF_HOLD, 32'h3);
      opens = 0;
      wr(OFF_CTRL, ctl(MODE_CONT, 1'b1, HEAT_OFF, 1'b1, 1'b0));
      wait_done();
      chk("hold", wid >= 3 * DIV && wid <= 3 * DIV + 2, 1'b1);
      st(8 * DIV);
      wr(OFF_HOLD, 32'h64);
      wr(OFF_CTRL, ctl(MODE_CONT, 1'b1, HEAT_OFF, 1'b1, 1'b0));
      st(10);
      wr(OFF_CTRL, ctl(MODE_CONT, 1'b1, HEAT_OFF, 1'b1, 1'b0));
      st(3);
      chk("second", o_open, 1'b0);
      st(10 * DIV);
      wr(OFF_CTRL, ctl(MODE_EXT, 1'b1, HEAT_OFF, 1'b0, 1'b0));
      repeat (6) begin
         v = $urandom % 2;
         u_drv.level(v[0]);
         st(6);
         chk("ext", o_open, v[0]);
         chk("ext done", o_done, 1'b0);
      end
      u_drv.level(1'b0);
      wr(OFF_CTRL, ctl(MODE_TIMED, 1'b0, HEAT_OFF, 1'b0, 1'b0));
      wr(OFF_ICLR, 32'hF);
      st(3);
      chk("off drive", o_drive, 1'b0);
      chk("off open", o_open, 1'b1);
      rc(OFF_STAT, 32'h10);
      u_drv.pulse(2);
      st(6);
      rc(OFF_ISTAT, 32'h8);
      wr(OFF_CTRL, ctl(MODE_TIMED, 1'b1, HEAT_OFF, 1'b0, 1'b0));
      st(3);
      chk("on open", o_open, 1'b0);
      for (int h = 0; h < 4; h++) begin
         @(posedge clk);
         heat_in <= 1'($urandom % 2);
         wr(OFF_CTRL, ctl(MODE_TIMED, 1'b1, h[1:0], 1'b0, 1'b0));
         st(6);
         chk("heat", o_heat, h == 1 || (h == 2 && heat_in));
      end
      wr(OFF_ICLR, 32'hF);
      repeat (6) begin
         @(posedge clk);
         temp <= 8'h36 + 8'($urandom % 3);
         st(3);
         chk("ovt", o_ovt, temp >= 8'h37);
      end
      @(posedge clk);
      temp <= 8'h37;
      st(3);
      rc(OFF_ISTAT, 32'h2);
      @(posedge clk);
      temp <= 8'h19;
      wr(OFF_OPEN, 32'h7);
      wr(OFF_ICLR, 32'hF);
      saw_disp = 1'b0;
      wr(OFF_CTRL, ctl(MODE_TIMED, 1'b1, HEAT_OFF, 1'b0, 1'b1));
      st(2);
      chk("restart", saw_disp, 1'b1);
      rc(OFF_OPEN, 32'hA);
      rc(OFF_ISTAT, 32'h4);
      summarize();
   end
endmodule : vds_tb_top
